// ===== verilog/meter_host_pkg.sv
/*
   Constants for the metering host controller: register map, fields,
   timing, word counts. Assumes a 100 MHz ref_clk; the controller, receiver and bench import it.
*/
`default_nettype none
package meter_host_pkg;

   // ----------------------------------------------------------------
   // Clock and serial timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ          = 100000000;
   localparam int SPI_MAX_HZ      = 2500000;
   // Half period rounded up so sclk never exceeds the maximum
   localparam int SCLK_HALF_CYC   = (CLK_HZ + 2 * SPI_MAX_HZ - 1)
                                    / (2 * SPI_MAX_HZ);
   localparam int TOGGLE_HOLD_NS  = 1000;
   localparam int TOGGLE_HOLD_CYC = (TOGGLE_HOLD_NS * (CLK_HZ / 1000000)
                                    + 999) / 1000;
   localparam int TOGGLE_COUNT    = 3;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int HDR_BITS   = 24;   // command byte plus 16-bit address
   localparam int FRAME_BITS = 56;   // header plus widest value
   localparam logic [6:0] CMD_UPPER = 7'h00; // differs from I2C address

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_ADDR    = 8'h04;
   localparam logic [7:0] OFS_WDATA   = 8'h08;
   localparam logic [7:0] OFS_RDATA   = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_CAPDATA = 8'h14;
   localparam logic [7:0] OFS_CAPCFG  = 8'h18;

   // CTRL fields
   localparam int CTRL_START  = 0;
   localparam int CTRL_READ   = 1;
   localparam int CTRL_WID_LO = 2;   // [3:2]: 0 = 8, 1 = 16, else 32 bits
   localparam int CTRL_SELECT = 4;   // run the three-toggle selection
   // STATUS fields
   localparam int ST_BUSY     = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_SPISEL   = 2;
   localparam int ST_CAPNEW   = 3;
   localparam int ST_CAPIDX   = 4;   // [7:4]
   // CAPCFG fields
   localparam int CC_ENABLE   = 0;
   localparam int CC_POL      = 1;
   localparam int CC_SET_LO   = 2;   // [3:2]

   localparam logic [3:0] CAPCFG_RESET = 4'h0;

   // Words per capture frame for each word set
   localparam logic [4:0] WORDS_ALL   = 5'd16;
   localparam logic [4:0] WORDS_WAVE  = 5'd7;
   localparam logic [4:0] WORDS_POWER = 5'd9;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

// ===== verilog/cap_if.sv
/*
   Controller core to capture receiver link.
   Assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface cap_if;
   logic        enable;     // Receiver armed
   logic        pol;        // Select active high when set
   logic [4:0]  limit;      // Words per frame
   logic [31:0] word;       // Last word completed
   logic [3:0]  index;      // Slot of that word
   logic        wordValid;  // One-cycle pulse per word

   modport ctl (output enable, output pol, output limit,
                input word, input index, input wordValid);
   modport rx  (input enable, input pol, input limit,
                output word, output index, output wordValid);
endinterface
`default_nettype wire

// ===== verilog/capture_receiver.sv
/*
   Capture port receiver: syncs select, clock and data pins, builds
   32-bit words MSB first on rising capture clock while select is
   active. Assumes capture clock at most 8 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
module capture_receiver (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Capture pins from the device
   input  wire logic captureClock,
   input  wire logic captureData,
   input  wire logic captureSelect,
   // Controller side
   cap_if.rx         cap
);
   import meter_host_pkg::*;

   logic [2:0]  clkSync_r;
   logic [1:0]  datSync_r;
   logic [1:0]  selSync_r;
   logic [31:0] shift_r;
   logic [4:0]  bitCnt_r;
   logic [4:0]  slot_r;
   logic        active;
   logic        rise;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two stages per pin; third clock stage only finds edges
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkSync_r <= 3'h7;
         datSync_r <= 2'h3;
         selSync_r <= 2'h3;
      end else begin
         clkSync_r <= {clkSync_r[1:0], captureClock};
         datSync_r <= {datSync_r[0], captureData};
         selSync_r <= {selSync_r[0], captureSelect};
      end
   end

   // Select level follows the programmed polarity [R23]
   assign active = selSync_r[1] ^ ~cap.pol;
   // Receiver samples on the rising capture clock edge [R18]
   assign rise   = clkSync_r[1] & ~clkSync_r[2];

   // ----------------------------------------------------------------
   // Word assembly
   // ----------------------------------------------------------------
   // MSB first; 8-bit packages simply accumulate to 32 bits [R19]
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r       <= 32'h0;
         bitCnt_r      <= 5'h0;
         slot_r        <= 5'h0;
         cap.word      <= 32'h0;
         cap.index     <= 4'h0;
         cap.wordValid <= 1'b0;
      end else begin
         cap.wordValid <= 1'b0;
         if (!cap.enable) begin
            bitCnt_r <= 5'h0;
            slot_r   <= 5'h0;
         end else if (rise && active) begin   // Gaps idle select [R20]
            shift_r  <= {shift_r[30:0], datSync_r[1]};
            bitCnt_r <= bitCnt_r + 5'h1;
            if (bitCnt_r == 5'h1f) begin
               cap.word      <= {shift_r[30:0], datSync_r[1]};
               cap.index     <= slot_r[3:0];
               cap.wordValid <= 1'b1;
               // Frame length set by the word set [R21] [R25]
               slot_r <= (slot_r + 5'h1 >= cap.limit) ? 5'h0
                                                      : slot_r + 5'h1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== verilog/meter_spi_host.sv
/*
   Host controller for a polyphase metering device. Software programs it
   over AXI4-Lite; it selects the device's serial port with three select
   toggles, runs register reads and writes as serial-clock master, and
   receives the device's capture-port words. Assumes ref_clk at 100 MHz
   and that the testbench resolves the shared data wire from mosiOe.
*/
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - Drive data on falling, device samples rising
// R2 - Capture device data MSB first on rising
// R3 - Serial clock never above 2.5 MHz
// R4 - Device output idles high impedance
// R5 - Select held low for whole transfer
// R6 - Read back written registers to confirm
// R7 - Command bit 0 high requests read
// R8 - Command bit 0 low requests write
// R9 - Read data follows address without gap
// R10 - Raise select and clock after last bit
// R11 - Write value follows address, no idle clocks
// R12 - Capture port off until enabled
// R13 - Up to sixteen sign-extended 32-bit words
// R14 - Missing values arrive as zero words
// R15 - Capture port is master toward us
// R16 - Shared data and select pins high after reset
// R17 - Configure capture before enabling it
// R18 - Capture data sampled on rising clock
// R19 - Packages sent MSB first, 32 or 8 bits
// R20 - Optional seven-clock gaps between packages
// R21 - Word set chooses sixteen, seven or nine
// R22 - Word set 11 acts as 00
// R23 - Select polarity bit inverts active level
// R24 - Three select falls choose serial port
// R25 - Capture frame each sample period
// R26 - Data width follows addressed register; host takes it from the CTRL width field [3:2]
module meter_spi_host (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial port pins toward the device
   output logic             sclk,
   output logic             selectN,
   output logic             mosiOut,
   output logic             mosiOe,
   input  wire logic        miso,
   // Capture port pins from the device
   input  wire logic        captureClock,
   input  wire logic        captureData,
   input  wire logic        captureSelect
);
   import meter_host_pkg::*;

   typedef enum {S_IDLE, S_TOG_LO, S_TOG_HI, S_SETUP, S_LOW, S_HIGH,
                 S_END} state_t;

   state_t                  state_r;
   logic [15:0]             addr_r;
   logic [31:0]             wdata_r;
   logic [31:0]             rdata_r;
   logic [4:0]              ctrl_r;
   logic [3:0]              capCfg_r;
   logic                    done_r;
   logic                    spiSel_r;
   logic                    capNew_r;
   logic [31:0]             capWord_r;
   logic [3:0]              capIdx_r;
   logic [FRAME_BITS-1:0]   tx_r;
   logic [5:0]              bitCnt_r;
   logic [5:0]              totalBits_r;
   logic                    isRead_r;
   logic [7:0]              timer_r;
   logic [1:0]              togCnt_r;
   logic [1:0]              misoSync_r;
   logic                    wrFire;
   logic                    rdFire;
   logic                    startReq;
   logic                    selReq;
   logic [5:0]              dataBits;
   logic [31:0]             dataAligned;
   logic [7:0]              cmdByte;
   logic                    timerDone;
   logic [1:0]              wordSet;

   cap_if cap ();

   // ----------------------------------------------------------------
   // Capture receiver
   // ----------------------------------------------------------------
   // Port is off until software sets enable, and again once the serial port is selected [R12] [R17]
   assign cap.enable = capCfg_r[CC_ENABLE] & ~spiSel_r;
   assign cap.pol    = capCfg_r[CC_POL];
   assign wordSet    = capCfg_r[CC_SET_LO +: 2];
   // Reserved 11 treated as 00 [R22]
   assign cap.limit  = (wordSet == 2'b01) ? WORDS_WAVE :
                       (wordSet == 2'b10) ? WORDS_POWER : WORDS_ALL; // [R21]

   capture_receiver u_rx (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .captureClock  (captureClock),
      .captureData   (captureData),
      .captureSelect (captureSelect),
      .cap           (cap)
   );

   // Latest word and slot; zero words pass as sent [R13] [R14]
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         capWord_r <= 32'h0;
         capIdx_r  <= 4'h0;
      end else if (cap.wordValid) begin
         capWord_r <= cap.word;
         capIdx_r  <= cap.index;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // Address and data taken together
   assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_wready  = s_axi_awready;
   assign wrFire        = s_axi_awready;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rdFire        = s_axi_arvalid & s_axi_arready;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         if (s_axi_awaddr <= OFS_CAPCFG && s_axi_awaddr[1:0] == 2'b00) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register writes
   assign startReq = wrFire && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0]
                     && s_axi_wdata[CTRL_START] && state_r == S_IDLE;
   assign selReq   = wrFire && s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0]
                     && s_axi_wdata[CTRL_SELECT] && state_r == S_IDLE;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r   <= 5'h0;
         addr_r   <= 16'h0;
         wdata_r  <= 32'h0;
         capCfg_r <= CAPCFG_RESET;
      end else if (wrFire) begin
         if (s_axi_awaddr == OFS_CTRL && state_r == S_IDLE) begin
            ctrl_r <= 5'(merge({27'h0, ctrl_r}, s_axi_wdata, s_axi_wstrb));
         end else if (s_axi_awaddr == OFS_ADDR) begin
            addr_r <= 16'(merge({16'h0, addr_r}, s_axi_wdata, s_axi_wstrb));
         end else if (s_axi_awaddr == OFS_WDATA) begin
            wdata_r <= merge(wdata_r, s_axi_wdata, s_axi_wstrb);
         end else if (s_axi_awaddr == OFS_CAPCFG) begin
            capCfg_r <= 4'(merge({28'h0, capCfg_r}, s_axi_wdata,
                                 s_axi_wstrb));
         end
      end
   end

   // Sticky flags: hardware set wins over write-one clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r   <= 1'b0;
         capNew_r <= 1'b0;
      end else begin
         if (state_r == S_END || (state_r == S_TOG_HI && timerDone
                                  && togCnt_r == 2'(TOGGLE_COUNT - 1))) begin
            done_r <= 1'b1;
         end else if (wrFire && s_axi_awaddr == OFS_STATUS
                      && s_axi_wstrb[0] && s_axi_wdata[ST_DONE]) begin
            done_r <= 1'b0;
         end
         if (cap.wordValid) begin
            capNew_r <= 1'b1;
         end else if (wrFire && s_axi_awaddr == OFS_STATUS
                      && s_axi_wstrb[0] && s_axi_wdata[ST_CAPNEW]) begin
            capNew_r <= 1'b0;
         end
      end
   end

   // Read data, one cycle after the address
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr == OFS_CTRL) begin
            s_axi_rdata <= {27'h0, ctrl_r};
         end else if (s_axi_araddr == OFS_ADDR) begin
            s_axi_rdata <= {16'h0, addr_r};
         end else if (s_axi_araddr == OFS_WDATA) begin
            s_axi_rdata <= wdata_r;
         end else if (s_axi_araddr == OFS_RDATA) begin
            s_axi_rdata <= rdata_r;
         end else if (s_axi_araddr == OFS_STATUS) begin
            s_axi_rdata <= {24'h0, capIdx_r, capNew_r, spiSel_r, done_r,
                            state_r != S_IDLE};
         end else if (s_axi_araddr == OFS_CAPDATA) begin
            s_axi_rdata <= capWord_r;
         end else if (s_axi_araddr == OFS_CAPCFG) begin
            s_axi_rdata <= {28'h0, capCfg_r};
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Serial transfer engine
   // ----------------------------------------------------------------
   // Value width from the CTRL width field [3:2], not the addressed register [R26]
   always_comb begin
      case (s_axi_wdata[CTRL_WID_LO +: 2])
         2'b00: begin
            dataBits    = 6'd8;
            dataAligned = {wdata_r[7:0], 24'h0};
         end
         2'b01: begin
            dataBits    = 6'd16;
            dataAligned = {wdata_r[15:0], 16'h0};
         end
         default: begin
            dataBits    = 6'd32;
            dataAligned = wdata_r;
         end
      endcase
   end

   // Upper bits fixed, bit 0 selects read or write [R7] [R8]
   assign cmdByte   = {CMD_UPPER, s_axi_wdata[CTRL_READ]};
   assign timerDone = (timer_r == 8'h0);

   // MISO passes two flops before sampling
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         misoSync_r <= 2'h0;
      end else begin
         misoSync_r <= {misoSync_r[0], miso};
      end
   end

   // Transfer and port-selection state machine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= S_IDLE;
         sclk        <= 1'b1;
         selectN     <= 1'b1;   // Shared pins idle high [R16]
         mosiOut     <= 1'b0;
         mosiOe      <= 1'b0;
         tx_r        <= '0;
         bitCnt_r    <= 6'h0;
         totalBits_r <= 6'h0;
         isRead_r    <= 1'b0;
         rdata_r     <= 32'h0;
         timer_r     <= 8'h0;
         togCnt_r    <= 2'h0;
         spiSel_r    <= 1'b0;
      end else begin
         if (!timerDone) begin
            timer_r <= timer_r - 8'h1;
         end
         case (state_r)
            S_IDLE: begin
               if (startReq) begin
                  tx_r        <= {cmdByte, addr_r, dataAligned};
                  totalBits_r <= 6'(HDR_BITS) + dataBits;
                  isRead_r    <= s_axi_wdata[CTRL_READ];
                  rdata_r     <= 32'h0;
                  bitCnt_r    <= 6'h0;
                  selectN     <= 1'b0;   // [R5]
                  mosiOe      <= 1'b1;
                  timer_r     <= 8'(SCLK_HALF_CYC - 1);
                  state_r     <= S_SETUP;
               end else if (selReq) begin
                  // Three select falls pick the port [R24]
                  togCnt_r <= 2'h0;
                  selectN  <= 1'b0;
                  timer_r  <= 8'(TOGGLE_HOLD_CYC - 1);
                  state_r  <= S_TOG_LO;
               end
            end
            S_TOG_LO: begin
               if (timerDone) begin
                  selectN <= 1'b1;
                  timer_r <= 8'(TOGGLE_HOLD_CYC - 1);
                  state_r <= S_TOG_HI;
               end
            end
            S_TOG_HI: begin
               if (timerDone) begin
                  if (togCnt_r == 2'(TOGGLE_COUNT - 1)) begin
                     spiSel_r <= 1'b1;   // [R24]
                     state_r  <= S_IDLE;
                  end else begin
                     togCnt_r <= togCnt_r + 2'h1;
                     selectN  <= 1'b0;
                     timer_r  <= 8'(TOGGLE_HOLD_CYC - 1);
                     state_r  <= S_TOG_LO;
                  end
               end
            end
            S_SETUP, S_HIGH: begin
               if (timerDone) begin
                  // Device data sampled late in the high half [R2] [R9]
                  if (state_r == S_HIGH && isRead_r
                      && bitCnt_r > 6'(HDR_BITS)) begin
                     rdata_r <= {rdata_r[30:0], misoSync_r[1]};
                  end
                  if (state_r == S_HIGH && bitCnt_r == totalBits_r) begin
                     state_r <= S_END;
                  end else begin
                     // Falling edge launches next bit, no idle cycle
                     sclk     <= 1'b0;                        // [R1] [R11]
                     mosiOut  <= tx_r[FRAME_BITS-1];
                     tx_r     <= {tx_r[FRAME_BITS-2:0], 1'b0};
                     bitCnt_r <= bitCnt_r + 6'h1;
                     timer_r  <= 8'(SCLK_HALF_CYC - 1);       // [R3]
                     state_r  <= S_LOW;
                  end
               end
            end
            S_LOW: begin
               if (timerDone) begin
                  sclk    <= 1'b1;   // Rising edge: device samples [R1]
                  timer_r <= 8'(SCLK_HALF_CYC - 1);
                  state_r <= S_HIGH;
               end
            end
            S_END: begin
               // End of frame: select high, data released [R10] [R4]
               selectN <= 1'b1;
               sclk    <= 1'b1;
               mosiOe  <= 1'b0;
               mosiOut <= 1'b0;
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== test/meter_spi_host_asserts.sv
/* Serial pin checks on the host controller.
   Bound to the top module; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module meter_spi_host_asserts (
   // Watched ports
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic selectN,
   input wire logic mosiOut,
   input wire logic mosiOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_data_rise: assert property ($rose(sclk) |-> $stable(mosiOut))
      else $error("mosi moved at rise");
   a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
      else $error("short low half");
   a_high_half: assert property ($rose(sclk) |-> sclk [*8])
      else $error("short high half");
   a_drive_sel: assert property (mosiOe |-> !selectN)
      else $error("driven while idle");
   a_sel_hold: assert property ($fell(selectN) |-> !selectN [*8])
      else $error("short select low");
   a_first_fall: assert property ($fell(selectN) |-> sclk [*8])
      else $error("early first fall");
   a_idle_clock: assert property (selectN |-> sclk)
      else $error("idle sclk low");
   a_end_high: assert property ($rose(selectN) |-> selectN [*8])
      else $error("short select high");
endmodule
bind meter_spi_host meter_spi_host_asserts u_meter_spi_host_asserts (
   .ref_clk, .rst_n, .sclk, .selectN, .mosiOut, .mosiOe);
`default_nettype wire

// ===== test/meter_device_model.sv
/* Device model: serial slave with one register, capture master
   sending words on demand. */
`timescale 1ns/100ps
`default_nettype none
module meter_device_model (
   // Serial port
   input  wire logic sclk,
   input  wire logic selectN,
   input  wire logic mosi,
   output logic      miso,
   // Capture port
   output logic      captureClock,
   output logic      captureData,
   output logic      captureSelect
);
   logic [31:0] store = 32'h0;
   logic [23:0] hdr = 24'h0;
   int          cnt = 0;
   int          falls = 0;
   int          wid;
   // Pins high out of reset
   initial begin
      {miso, captureClock, captureData, captureSelect} = 4'hf;
   end
   // Port choice by select falls
   always @(negedge selectN) falls++;
   // Abort or end clears frame, miso inverted
   always @(posedge selectN) begin
      cnt = 0;
      miso <= ~miso;
   end
   // Sample on rise; cmd bit 0 picks direction
   always @(posedge sclk) if (!selectN) begin
      if (cnt < 24) hdr = {hdr[22:0], mosi};
      else if (!hdr[16] && falls >= 3) store = {store[30:0], mosi};
      cnt++;
   end
   // Read data MSB first after the address
   always @(negedge sclk) if (!selectN && hdr[16] && cnt >= 24) begin
      wid = (hdr[1:0] == 2'h0) ? 8 : (hdr[1:0] == 2'h1) ? 16 : 32;
      miso <= (cnt - 24 < wid) ? store[wid - 1 - (cnt - 24)] : ~miso;
   end
   // One word, clock only in frame, data set on fall
   task automatic send_word(input logic [31:0] w, input logic pol);
      captureSelect = pol;
      for (int i = 31; i >= 0; i--) begin
         captureClock = 1'b0;
         captureData = w[i];
         #62.5 captureClock = 1'b1;
         #62.5;
      end
      captureSelect = ~pol;
      captureData = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== test/test_meter_spi_host.sv
/* Bench for the metering host controller: AXI4-Lite
   stimulus, device model on the pins. */
`timescale 1ns/100ps
`default_nettype none
module test_meter_spi_host;
   import meter_host_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_rdata, rd, v;
   logic        sclk, selectN, mosiOut, mosiOe, miso;
   logic        captureClock, captureData, captureSelect;
   wire logic   mosi;
   int          errors = 0;
   int          comparisons = 0;
   assign mosi = mosiOe ? mosiOut : 1'bz;
   meter_spi_host u_meter_spi_host (.*);
   meter_device_model u_meter_device_model (.*);
   initial forever #5 ref_clk = ~ref_clk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      if (errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Bounded wait for a handshake
   task automatic wt(ref logic s);
      int i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (s !== 1'b1 && i < 9000);
      if (s !== 1'b1) begin
         errors++;
         close_out;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wt(s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wt(s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wt(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      wt(s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Poll done, then clear it
   task automatic done_wait;
      int i = 0;
      do begin
         rd_reg(OFS_STATUS);
         i++;
      end while (rd[1] !== 1'b1 && i < 3000);
      if (rd[1] !== 1'b1) begin
         errors++;
         close_out;
      end
      wr(OFS_STATUS, 32'h2);
   endtask
   task spi(input logic [1:0] w, input logic r, input logic [31:0] d);
      wr(OFS_ADDR, {30'h0, w});
      wr(OFS_WDATA, d);
      wr(OFS_CTRL, {28'h0, w, r, 1'b1});
      done_wait;
   endtask
   task t_reset;
      rd_reg(OFS_CAPCFG);
      chk(rd, 32'h0);
      chk({30'h0, sclk, selectN}, 32'h3);
      rd_reg(8'h1c);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR});
   endtask
   task t_capture;
      u_meter_device_model.send_word(32'hfff81234, 1'b0);
      rd_reg(OFS_STATUS);
      chk(rd & 32'h8, 32'h0);
      wr(OFS_CAPCFG, 32'h1);
      u_meter_device_model.send_word(32'hfff81234, 1'b0);
      rd_reg(OFS_CAPDATA);
      chk(rd, 32'hfff81234);
      rd_reg(OFS_STATUS);
      chk(rd & 32'hf8, 32'h8);
      wr(OFS_CAPCFG, 32'h3);
      u_meter_device_model.send_word(32'h00005a5a, 1'b1);
      rd_reg(OFS_CAPDATA);
      chk(rd, 32'h00005a5a);
   endtask
   task t_select;
      wr(OFS_CTRL, 32'h10);
      done_wait;
      chk(rd & 32'h4, 32'h4);
      u_meter_device_model.send_word(32'h11111111, 1'b1);
      rd_reg(OFS_CAPDATA);
      chk(rd, 32'h00005a5a);
   endtask
   // Write then read back each width
   task t_spi;
      int w;
      for (w = 0; w < 3; w++) begin
         v = 32'hc3a5965a >> ((w == 0) ? 24 : (w == 1) ? 16 : 0);
         spi(w[1:0], 1'b0, v);
         spi(w[1:0], 1'b1, 32'h0);
         rd_reg(OFS_RDATA);
         chk(rd, v);
      end
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset;
      t_capture;
      t_select;
      t_spi;
      close_out;
   end
endmodule
`default_nettype wire
